// *** logic/srs_pkg.sv ***
// Shared constants and carrier types for the system reset sequencer.
// Assumes one clock, clk_sys at 40 MHz; the filter widths and sequencing counts below are in its cycles.
package srs_pkg;

    // Filter widths, polarity defaults and copy counts.
    localparam int unsigned EXT_MIN_WIDTH_DEF  = 4;
    localparam int unsigned AUX_MIN_WIDTH_DEF  = 4;
    localparam int unsigned MIN_WIDTH_MAX      = 16;
    localparam bit          EXT_POL_HIGH_DEF   = 1'b1;
    localparam bit          AUX_POL_HIGH_DEF   = 1'b1;
    localparam int unsigned BUS_COPIES_DEF     = 1;
    localparam int unsigned PERIPH_HI_DEF      = 1;
    localparam int unsigned FABRIC_LOW_DEF     = 1;
    localparam int unsigned PERIPH_LOW_DEF     = 1;

    // Sequencing counts in clocks, and the bit width of their counter.
    localparam int unsigned POR_HOLD_CLKS      = 16;
    localparam int unsigned STAGE_GAP_CLKS     = 16;
    localparam int unsigned SEQ_CNT_W          = 5;

    // Reset-state values of the filtered request flags and the stage flags.
    localparam logic        REQ_RESET_VAL      = 1'b1;
    localparam logic        STAGE_RESET_VAL    = 1'b1;

    // Release stages in order.
    typedef enum logic [2:0] {
        SRS_POR,
        SRS_HOLD,
        SRS_REL_BUS,
        SRS_REL_PERIPH,
        SRS_RUN
    } srs_state_e;

    // Qualified reset requests after synchronising and filtering.
    typedef struct packed {
        logic ext;
        logic dbg;
        logic aux;
    } srs_req_s;

    // Internal active-high assert levels of the three reset groups.
    typedef struct packed {
        logic bus;
        logic periph;
        logic core;
    } srs_stage_s;

endpackage

// *** logic/srs_width_filter.sv ***
// Two-stage synchroniser followed by a minimum-width filter for one reset input.
// Assumes an asynchronous pin input and an input already mapped to active-high.
`timescale 1ns/1ps

module srs_width_filter
    import srs_pkg::*;
#(
    parameter int unsigned MIN_WIDTH = EXT_MIN_WIDTH_DEF
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic raw_req,
    output logic      req
);

    localparam int unsigned CW = $clog2(MIN_WIDTH + 1) + 1;
    localparam logic [CW-1:0] LAST = CW'(MIN_WIDTH - 1);

    logic          sync_a;
    logic          sync_b;
    logic [CW-1:0] run_cnt;

    // Two flops; only the second is read by the filter.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= raw_req;
            sync_b <= sync_a;
        end
    end

    // A change is taken only after it has stood MIN_WIDTH clocks.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_cnt <= '0;
            req     <= REQ_RESET_VAL;
        end else if (sync_b == req) begin
            run_cnt <= '0;
        end else if (run_cnt >= LAST) begin
            run_cnt <= '0;
            req     <= sync_b;
        end else begin
            run_cnt <= run_cnt + CW'(1);
        end
    end

endmodule

// *** logic/srs_copy_bank.sv ***
// A bank of individually registered copies of one reset level.
// Assumes the level comes from logic on clk_sys.
`timescale 1ns/1ps

module srs_copy_bank #(
    parameter int unsigned COPIES     = 1,
    parameter bit          ACTIVE_LOW = 1'b0
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              assert_lvl,
    output logic [COPIES-1:0]      rst_out
);

    localparam logic ASSERTED = ACTIVE_LOW ? 1'b0 : 1'b1;

    // Each copy has its own flop, so copies never share a driver.
    for (genvar i = 0; i < COPIES; i++) begin : g_copy
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                rst_out[i] <= ASSERTED;
            end else begin
                rst_out[i] <= assert_lvl ? ASSERTED : ~ASSERTED;
            end
        end
    end

endmodule

// *** logic/srs_top.sv ***
// Top of the system reset sequencer: input qualification, staged release, outputs.
// Assumes clk_sys is the slowest synchronous system clock and nrst a power-on reset.
`timescale 1ns/1ps

module srs_top
    import srs_pkg::*;
#(
    parameter int unsigned ext_min_width     = EXT_MIN_WIDTH_DEF,
    parameter int unsigned aux_min_width     = AUX_MIN_WIDTH_DEF,
    parameter bit          ext_polarity_high = EXT_POL_HIGH_DEF,
    parameter bit          aux_polarity_high = AUX_POL_HIGH_DEF,
    parameter int unsigned bus_reset_copies  = BUS_COPIES_DEF,
    parameter int unsigned periph_hi_copies  = PERIPH_HI_DEF,
    parameter int unsigned fabric_low_copies = FABRIC_LOW_DEF,
    parameter int unsigned periph_low_copies = PERIPH_LOW_DEF
) (
    input  wire logic                         clk_sys,
    input  wire logic                         nrst,
    input  wire logic                         ext_reset,
    input  wire logic                         debugger_system_reset,
    input  wire logic                         aux_reset,
    input  wire logic                         clk_locked,
    output logic                              processor_reset,
    output logic [bus_reset_copies-1:0]       bus_reset,
    output logic [periph_hi_copies-1:0]       periph_reset,
    output logic [fabric_low_copies-1:0]      fabric_reset_n,
    output logic [periph_low_copies-1:0]      periph_reset_n
);

    localparam logic [SEQ_CNT_W-1:0] POR_LAST = SEQ_CNT_W'(POR_HOLD_CLKS - 1);
    localparam logic [SEQ_CNT_W-1:0] GAP_LAST = SEQ_CNT_W'(STAGE_GAP_CLKS - 1);

    srs_req_s              req;
    srs_state_e            state;
    srs_state_e            next_state;
    logic [SEQ_CNT_W-1:0]  seq_cnt;
    logic                  lock_a;
    logic                  lock_b;
    logic                  any_req;
    logic                  hold;
    srs_stage_s            stage;
    srs_stage_s            next_stage;

    // Map each pin to an active-high request level before filtering.
    logic ext_raw;
    logic aux_raw;
    assign ext_raw = ext_polarity_high ? ext_reset : ~ext_reset;
    assign aux_raw = aux_polarity_high ? aux_reset : ~aux_reset;

    // External input, synchronised and width filtered.
    srs_width_filter #(
        .MIN_WIDTH (ext_min_width)
    ) u_ext_filt (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .raw_req (ext_raw),
        .req     (req.ext)
    );

    // Debugger input, always active-high, same width as the external input.
    srs_width_filter #(
        .MIN_WIDTH (ext_min_width)
    ) u_dbg_filt (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .raw_req (debugger_system_reset),
        .req     (req.dbg)
    );

    // Auxiliary input with its own width.
    srs_width_filter #(
        .MIN_WIDTH (aux_min_width)
    ) u_aux_filt (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .raw_req (aux_raw),
        .req     (req.aux)
    );

    // Lock comes from the clock generator, so it is synchronised too.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lock_a <= 1'b0;
            lock_b <= 1'b0;
        end else begin
            lock_a <= clk_locked;
            lock_b <= lock_a;
        end
    end

    // Any request, or a missing lock, forces the hold condition.
    assign any_req = req.ext | req.dbg | req.aux;
    assign hold    = any_req | ~lock_b;

    // Release sequencer: power-on hold, then staged release.
    always_comb begin
        next_state = state;
        unique case (state)
            SRS_POR: begin
                if (seq_cnt == POR_LAST) begin
                    next_state = SRS_HOLD;
                end
            end
            SRS_HOLD: begin
                if (!hold) begin
                    next_state = SRS_REL_BUS;
                end
            end
            SRS_REL_BUS: begin
                if (hold) begin
                    next_state = SRS_HOLD;
                end else if (seq_cnt == GAP_LAST) begin
                    next_state = SRS_REL_PERIPH;
                end
            end
            SRS_REL_PERIPH: begin
                if (hold) begin
                    next_state = SRS_HOLD;
                end else if (seq_cnt == GAP_LAST) begin
                    next_state = SRS_RUN;
                end
            end
            SRS_RUN: begin
                if (hold) begin
                    next_state = SRS_HOLD;
                end
            end
        endcase
    end

    // State register; the power-on hold starts from the reset release.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= SRS_POR;
        end else begin
            state <= next_state;
        end
    end

    // Counter restarts at every state change and counts within a stage.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            seq_cnt <= '0;
        end else if (next_state != state) begin
            seq_cnt <= '0;
        end else if (seq_cnt != '1) begin
            seq_cnt <= seq_cnt + SEQ_CNT_W'(1);
        end
    end

    // Group assert levels follow the next state, so all assert on one edge.
    always_comb begin
        next_stage.bus    = (next_state == SRS_POR) || (next_state == SRS_HOLD);
        next_stage.periph = next_stage.bus || (next_state == SRS_REL_BUS);
        next_stage.core   = next_stage.periph || (next_state == SRS_REL_PERIPH);
    end

    // Stage flags and the core output register next_stage; the copy banks take next_stage directly.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage           <= {STAGE_RESET_VAL, STAGE_RESET_VAL, STAGE_RESET_VAL};
            processor_reset <= STAGE_RESET_VAL;
        end else begin
            stage           <= next_stage;
            processor_reset <= next_stage.core;
        end
    end

    // Bus-structure copies, active-high.
    srs_copy_bank #(
        .COPIES     (bus_reset_copies),
        .ACTIVE_LOW (1'b0)
    ) u_bus (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .assert_lvl (next_stage.bus),
        .rst_out    (bus_reset)
    );

    // Interconnect copies, active-low, released with the bus group.
    srs_copy_bank #(
        .COPIES     (fabric_low_copies),
        .ACTIVE_LOW (1'b1)
    ) u_fabric (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .assert_lvl (next_stage.bus),
        .rst_out    (fabric_reset_n)
    );

    // Active-high peripheral copies.
    srs_copy_bank #(
        .COPIES     (periph_hi_copies),
        .ACTIVE_LOW (1'b0)
    ) u_periph_hi (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .assert_lvl (next_stage.periph),
        .rst_out    (periph_reset)
    );

    // Active-low peripheral copies.
    srs_copy_bank #(
        .COPIES     (periph_low_copies),
        .ACTIVE_LOW (1'b1)
    ) u_periph_low (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .assert_lvl (next_stage.periph),
        .rst_out    (periph_reset_n)
    );

    // Cycles since the bus and peripheral groups left reset, saturating; the gap checks count on these.
    localparam logic [5:0] AGE_MAX = 6'h3f;
    localparam logic [5:0] GAP_AGE = 6'(STAGE_GAP_CLKS);

    logic [5:0] bus_age;
    logic [5:0] per_age;

    // Bus group age restarts while the bus reset is asserted.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus_age <= '0;
        end else if (bus_reset[0]) begin
            bus_age <= '0;
        end else if (bus_age != AGE_MAX) begin
            bus_age <= bus_age + 6'h01;
        end
    end

    // Peripheral group age restarts while the peripheral reset is asserted.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            per_age <= '0;
        end else if (periph_reset[0]) begin
            per_age <= '0;
        end else if (per_age != AGE_MAX) begin
            per_age <= per_age + 6'h01;
        end
    end

    // Named steps of the release sequence.
    sequence s_bus_released;
        $fell(bus_reset[0]);
    endsequence

    sequence s_periph_released;
        $fell(periph_reset[0]);
    endsequence

    sequence s_core_released;
        $fell(processor_reset);
    endsequence

    AST_PERIPH_AFTER_BUS: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        s_bus_released |-> periph_reset[0] && processor_reset)
        else $error("Peripheral release order broken.");

    AST_PERIPH_16_LATER: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        s_periph_released |-> bus_age == GAP_AGE)
        else $error("Peripheral reset not released 16 clocks after bus reset.");

    AST_CORE_16_AFTER_PERIPH: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        s_core_released |-> per_age == GAP_AGE)
        else $error("Processor reset not released 16 clocks after peripherals.");

    AST_CORE_LAST: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        periph_reset[0] |-> processor_reset)
        else $error("Processor reset released before peripherals.");

    AST_TOGETHER: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(processor_reset) |-> bus_reset[0] && periph_reset[0]
            && !fabric_reset_n[0] && !periph_reset_n[0])
        else $error("Reset outputs did not assert together.");

    AST_POLARITY_PAIRS: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (fabric_reset_n[0] == !bus_reset[0]) && (periph_reset_n[0] == !periph_reset[0]))
        else $error("Active-low outputs disagree with active-high outputs.");

    AST_REQ_REASSERTS: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (hold && state != SRS_POR) |=> bus_reset[0] && processor_reset)
        else $error("Reset request did not reassert outputs.");

    AST_POR_HOLD: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (state == SRS_POR) |-> processor_reset && bus_reset[0] && !$fell(bus_reset[0]))
        else $error("Outputs released during power-on hold.");

    AST_COPIES_AGREE: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (bus_reset == {bus_reset_copies{stage.bus}})
        && (fabric_reset_n == ~{fabric_low_copies{stage.bus}})
        && (periph_reset == {periph_hi_copies{stage.periph}})
        && (periph_reset_n == ~{periph_low_copies{stage.periph}})
        && (processor_reset == stage.core))
        else $error("Reset copies disagree with their group level.");

endmodule

// *** tb/srs_consumer_model.sv ***
// Model of the logic that consumes the sequencer's resets: core, fabric and peripherals.
// Assumes it shares clk_sys with the sequencer and sees copy zero of each vector.
`timescale 1ns/1ps

module srs_consumer_model (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic bus_rst,
    input  wire logic fabric_rst_n,
    input  wire logic periph_rst,
    input  wire logic periph_rst_n,
    input  wire logic core_rst,
    output int        gap_per,
    output int        gap_core,
    output logic      order_err
);
    int   cyc = 0;
    int   t_bus;
    int   t_per;
    logic bus_q;
    logic per_q;
    logic core_q;

    // Time each release step and flag a group leaving reset out of turn.
    // While nrst is low nothing has been released yet, so the results restart.
    always @(posedge clk_sys) begin
        cyc    <= cyc + 1;
        bus_q  <= bus_rst;
        per_q  <= periph_rst;
        core_q <= core_rst;
        if (!nrst) begin
            gap_per   <= -1;
            gap_core  <= -1;
            order_err <= 1'b0;
        end else begin
            if (bus_rst && !bus_q) begin
                gap_per  <= -1;
                gap_core <= -1;
            end
            if (bus_q && !bus_rst) t_bus <= cyc;
            if (per_q && !periph_rst) begin
                t_per   <= cyc;
                gap_per <= cyc - t_bus;
            end
            if (core_q && !core_rst) gap_core <= cyc - t_per;
            if ((!periph_rst && bus_rst) || (!core_rst && periph_rst) ||
                fabric_rst_n !== ~bus_rst || periph_rst_n !== ~periph_rst) begin
                order_err <= 1'b1;
            end
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the system reset sequencer.
// Assumes inputs change at falling edges and the design samples on rising edges.
`timescale 1ns/1ps

module tb
    import srs_pkg::*;
;
    localparam int EXT_W  = 3;
    localparam int AUX_W  = 5;
    localparam int BUS_N  = 2;
    localparam int PHI_N  = 3;
    localparam int FAB_N  = 2;
    localparam int PLO_N  = 4;
    localparam int PERIOD = 25;

    logic             clk_sys;
    logic             nrst;
    logic             ext_reset;
    logic             debugger_system_reset;
    logic             aux_reset;
    logic             clk_locked;
    logic             processor_reset;
    logic [BUS_N-1:0] bus_reset;
    logic [PHI_N-1:0] periph_reset;
    logic [FAB_N-1:0] fabric_reset_n;
    logic [PLO_N-1:0] periph_reset_n;
    int               gap_per;
    int               gap_core;
    logic             order_err;
    int               num_errors   = 0;
    int               total_checks = 0;

    // External reset is active low here; widths stay within the advised range.
    srs_top #(.ext_min_width(EXT_W), .aux_min_width(AUX_W),
              .ext_polarity_high(1'b0), .aux_polarity_high(1'b1),
              .bus_reset_copies(BUS_N), .periph_hi_copies(PHI_N),
              .fabric_low_copies(FAB_N), .periph_low_copies(PLO_N)) dut_u (
        .clk_sys(clk_sys), .nrst(nrst), .ext_reset(ext_reset),
        .debugger_system_reset(debugger_system_reset), .aux_reset(aux_reset),
        .clk_locked(clk_locked), .processor_reset(processor_reset),
        .bus_reset(bus_reset), .periph_reset(periph_reset),
        .fabric_reset_n(fabric_reset_n), .periph_reset_n(periph_reset_n));

    srs_consumer_model far_u (
        .clk_sys(clk_sys), .nrst(nrst), .bus_rst(bus_reset[0]),
        .fabric_rst_n(fabric_reset_n[0]), .periph_rst(periph_reset[0]),
        .periph_rst_n(periph_reset_n[0]), .core_rst(processor_reset),
        .gap_per(gap_per), .gap_core(gap_core), .order_err(order_err));

    // Second copy with default copy counts and opposite pin polarities, fed inverted pins,
    // so it must follow the first copy edge for edge.
    logic       alt_ext;
    logic       alt_aux;
    logic [4:0] alt_out;
    assign alt_ext = ~ext_reset;
    assign alt_aux = ~aux_reset;
    srs_top #(.ext_min_width(EXT_W), .aux_min_width(AUX_W),
              .aux_polarity_high(1'b0)) alt_u (
        .clk_sys(clk_sys), .nrst(nrst), .ext_reset(alt_ext),
        .debugger_system_reset(debugger_system_reset), .aux_reset(alt_aux),
        .clk_locked(clk_locked), .processor_reset(alt_out[0]),
        .bus_reset(alt_out[4]), .periph_reset(alt_out[3]),
        .fabric_reset_n(alt_out[2]), .periph_reset_n(alt_out[1]));

    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Counts one comparison and reports a mismatch at once.
    task automatic check(logic [15:0] got, logic [15:0] exp, string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Compares every copy of every reset group with the expected assert levels.
    task automatic check_grp(bit b, bit p, bit c);
        check(16'(bus_reset), 16'({BUS_N{b}}), "bus reset");
        check(16'(fabric_reset_n), 16'({FAB_N{~b}}), "fabric reset");
        check(16'(periph_reset), 16'({PHI_N{p}}), "periph reset");
        check(16'(periph_reset_n), 16'({PLO_N{~p}}), "periph reset n");
        check(16'(processor_reset), 16'(c), "processor reset");
        check(16'(alt_out), 16'({b, p, ~b, ~p, c}), "default polarity copy");
    endtask

    // Drives one request source to its active or idle level.
    task automatic drive_req(int which, bit act);
        case (which)
            0: ext_reset = ~act;
            1: debugger_system_reset = act;
            default: aux_reset = act;
        endcase
    endtask

    // Counts falling edges until the bus reset is seen asserted.
    task automatic wait_assert(output int n);
        n = 0;
        while (bus_reset[0] !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // Waits for the full release and checks its staging.
    task automatic wait_release(string name);
        int i;
        for (i = 0; i < 200 && processor_reset !== 1'b0; i++) @(negedge clk_sys);
        @(negedge clk_sys);
        check(16'(gap_per), 16'(STAGE_GAP_CLKS), "bus to periph gap");
        check(16'(gap_core), 16'(STAGE_GAP_CLKS), "periph to core gap");
        check(16'(order_err), 16'h0000, "release order");
        check_grp(1'b0, 1'b0, 1'b0);
        $display("test %s done", name);
    endtask

    // Power-on hold and the first release.
    task automatic t_power_on();
        repeat (10) @(negedge clk_sys);
        check_grp(1'b1, 1'b1, 1'b1);
        nrst = 1'b1;
        repeat (POR_HOLD_CLKS) @(negedge clk_sys);
        check_grp(1'b1, 1'b1, 1'b1);
        wait_release("power_on");
    endtask

    // A pulse one clock short is ignored; a held request asserts all groups at once.
    task automatic t_filter(int which, int w, string name);
        int n;
        drive_req(which, 1'b1);
        repeat (w - 1) @(negedge clk_sys);
        drive_req(which, 1'b0);
        repeat (12) @(negedge clk_sys);
        check_grp(1'b0, 1'b0, 1'b0);
        drive_req(which, 1'b1);
        wait_assert(n);
        check(16'(n >= w && n <= w + 5), 16'h0001, "assert latency");
        check_grp(1'b1, 1'b1, 1'b1);
        drive_req(which, 1'b0);
        wait_release(name);
    endtask

    // Lock loss asserts everything and holds it until lock returns.
    task automatic t_lock();
        int n;
        clk_locked = 1'b0;
        wait_assert(n);
        check(16'(n <= 6), 16'h0001, "lock loss latency");
        repeat (40) @(negedge clk_sys);
        check_grp(1'b1, 1'b1, 1'b1);
        clk_locked = 1'b1;
        wait_release("lock");
    endtask

    // A new request part way through release reasserts every group.
    task automatic t_reassert();
        int n;
        int i;
        drive_req(0, 1'b1);
        wait_assert(n);
        drive_req(0, 1'b0);
        for (i = 0; i < 60 && bus_reset[0] !== 1'b0; i++) @(negedge clk_sys);
        repeat (8) @(negedge clk_sys);
        check_grp(1'b0, 1'b1, 1'b1);
        drive_req(1, 1'b1);
        wait_assert(n);
        check(16'(n <= EXT_W + 5), 16'h0001, "reassert latency");
        check_grp(1'b1, 1'b1, 1'b1);
        drive_req(1, 1'b0);
        wait_release("reassert");
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short well after the expected run length.
    initial begin
        #(PERIOD * 6000);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

    // Main sequence.
    initial begin
        nrst                  = 1'b0;
        ext_reset             = 1'b1;
        debugger_system_reset = 1'b0;
        aux_reset             = 1'b0;
        clk_locked            = 1'b1;
        t_power_on();
        t_filter(0, EXT_W, "ext_low");
        t_filter(1, EXT_W, "debugger");
        t_filter(2, AUX_W, "aux_high");
        t_lock();
        t_reassert();
        end_of_test();
    end
endmodule
